// [hdl/pager_param_defs.svh]
// Constants for the paging decoder parameter control block.
`ifndef PAGER_PARAM_DEFS_SVH
`define PAGER_PARAM_DEFS_SVH
`define CLK_PERIOD_NS     20
`define WORD_BITS         32
`define CMD_CODE          7'h20
`define CMD_MSB           31
`define CMD_LSB           25
`define BIT_DC_OPT        24
`define BIT_MSG_END       23
`define BIT_AUX_FREQ      22
`define BIT_AUX_OFF       21
`define RATE_MSB          20
`define RATE_LSB          19
`define BIT_POLARITY      18
`define PLL_MSB           17
`define PLL_LSB           12
`define RADIO_MSB         11
`define RADIO_LSB         6
`define BIT_FILT_EN       5
`define FILT_MSB          4
`define FILT_LSB          3
`define RERR_MSB          2
`define RERR_LSB          0
`define LEAD_MIN          6'h02
`define LEAD_MAX          6'h3e
`define LEAD_START        6'h3f
`define PARAM_RESET       32'h40000000
`define LIMIT_RESET       4'h1
`define STEP_512_NS       1953000
`define STEP_1200_NS      833000
`define STEP_2400_NS      417000
`define SLOT_512_NS       62500000
`define SLOT_1200_NS      26700000
`define SLOT_2400_NS      13400000
`define IN_RANGE_NS       1000000000
`define AUX_FAST_HZ       76800
`define CLK_HZ            50000000
`define FILT_BASE_CYC     64
`endif

// [hdl/pager_param_pkg.sv]
// Types shared by the paging decoder parameter control block.
package pager_param_pkg;
  typedef enum logic [1:0] {RATE_512, RATE_1200, RATE_2400, RATE_BAD} rate_e;
  typedef enum logic [1:0] {MODE_PREAMBLE, MODE_LOCK, MODE_IDLE, MODE_OFF}
    mode_e;
  typedef enum logic [1:0] {ST_WAIT, ST_LEAD, ST_SLOT} strobe_st_e;
endpackage

// [hdl/pager_param_ctrl.sv]
// Parameter word capture and application for the paging decoder.
`timescale 1ns/1ps
`default_nettype none
`include "pager_param_defs.svh"

module pager_param_ctrl #(
  parameter int STEP_512_CYC  = `STEP_512_NS / `CLK_PERIOD_NS,
  parameter int STEP_1200_CYC = `STEP_1200_NS / `CLK_PERIOD_NS,
  parameter int STEP_2400_CYC = `STEP_2400_NS / `CLK_PERIOD_NS,
  parameter int SLOT_512_CYC  = `SLOT_512_NS / `CLK_PERIOD_NS,
  parameter int SLOT_1200_CYC = `SLOT_1200_NS / `CLK_PERIOD_NS,
  parameter int SLOT_2400_CYC = `SLOT_2400_NS / `CLK_PERIOD_NS,
  parameter int IN_RANGE_CYC  = (`IN_RANGE_NS + `CLK_PERIOD_NS - 1)
                                / `CLK_PERIOD_NS,
  parameter int FILT_BASE_CYC = `FILT_BASE_CYC
) (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       init_reset_n_in,
  input  wire logic       link_clk_in,
  input  wire logic       link_data_in,
  input  wire logic       data_ready_in,
  input  wire logic       signal_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       idle_cycle_in,
  input  wire logic       sync_window_in,
  input  wire logic       sync_found_in,
  input  wire logic [2:0] sync_errors_in,
  input  wire logic       sync_missed_in,
  input  wire logic       in_message_in,
  input  wire logic       idle_code_in,
  input  wire logic       other_address_in,
  input  wire logic       break_cmd_in,
  output logic            attention_line_out,
  output logic            filtered_data_out,
  output logic            in_range_indicator_out,
  output logic            radio_power_strobe_out,
  output logic            dc_adjust_strobe_out,
  output logic            pll_setup_strobe_out,
  output logic            aux_clock_out,
  output logic            message_end_out,
  output logic            address_as_data_out,
  output logic [1:0]      rate_out,
  output logic [3:0]      rate_error_limit_out
);
  initial
  begin
    if (STEP_2400_CYC < 1 || SLOT_2400_CYC < 1 || IN_RANGE_CYC < 1 ||
        FILT_BASE_CYC < 1)
      $error("pager_param_ctrl: timing counts must be at least one");
  end

  localparam int AUX_HALF_CYC = `CLK_HZ / (2 * `AUX_FAST_HZ);

  // Link domain: shift in words on the host clock, then hand over.
  logic        lrst_a_ff, lrst_b_ff;
  logic [31:0] shift_ff, nxt_shift;
  logic [4:0]  bitcnt_ff, nxt_bitcnt;
  logic [31:0] hold_ff, nxt_hold;
  logic        ltgl_ff, nxt_ltgl;

  always_comb
  begin
    nxt_shift  = {shift_ff[30:0], link_data_in};
    nxt_bitcnt = bitcnt_ff + 5'h01;
    nxt_hold   = hold_ff;
    nxt_ltgl   = ltgl_ff;
    if (bitcnt_ff == 5'h1f)
    begin
      nxt_hold = nxt_shift;
      nxt_ltgl = ~ltgl_ff;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    lrst_a_ff <= reset_n_in;
    lrst_b_ff <= lrst_a_ff;
    if (!lrst_b_ff)
    begin
      shift_ff  <= 32'h00000000;
      bitcnt_ff <= 5'h00;
      hold_ff   <= 32'h00000000;
      ltgl_ff   <= 1'b0;
    end
    else
    begin
      shift_ff  <= nxt_shift;
      bitcnt_ff <= nxt_bitcnt;
      hold_ff   <= nxt_hold;
      ltgl_ff   <= nxt_ltgl;
    end
  end

  // Pin synchronisers; init reset joins the system reset.
  logic ini_a_ff, ini_b_ff, sig_a_ff, sig_b_ff, tg_a_ff, tg_b_ff, tg_c_ff;
  logic rst;

  always_ff @(posedge sys_clk_in)
  begin
    ini_a_ff <= init_reset_n_in;
    ini_b_ff <= ini_a_ff;
    sig_a_ff <= signal_in;
    sig_b_ff <= sig_a_ff;
    tg_a_ff  <= ltgl_ff;
    tg_b_ff  <= tg_a_ff;
    tg_c_ff  <= tg_b_ff;
  end

  assign rst = !reset_n_in || !ini_b_ff;

  // Parameter word: latched only when the command code and codes are legal.
  logic [31:0] param_ff, nxt_param;
  logic [3:0]  lim_ff, nxt_lim;
  logic        word_ok;
  logic [5:0]  new_pll, new_radio;

  always_comb
  begin
    new_pll   = hold_ff[`PLL_MSB:`PLL_LSB];
    new_radio = hold_ff[`RADIO_MSB:`RADIO_LSB];
    word_ok   = (hold_ff[`CMD_MSB:`CMD_LSB] == `CMD_CODE) &&
                (hold_ff[`RATE_MSB:`RATE_LSB] != 2'b11) &&
                (new_pll >= `LEAD_MIN) && (new_pll <= `LEAD_MAX) &&
                (new_radio >= `LEAD_MIN) && (new_radio < `LEAD_MAX) &&
                (new_pll > new_radio);
    nxt_param = param_ff;
    if ((tg_b_ff != tg_c_ff) && word_ok)
      nxt_param = hold_ff;
    nxt_lim = {1'b0, nxt_param[`RERR_MSB:`RERR_LSB]} + 4'h1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst)
    begin
      param_ff <= `PARAM_RESET;
      lim_ff   <= `LIMIT_RESET;
    end
    else
    begin
      param_ff <= nxt_param;
      lim_ff   <= nxt_lim;
    end
  end

  logic       dc_opt, aux_slow, aux_off, polarity, filt_en;
  logic [1:0] filt_sel;
  logic [5:0] pll_lead, radio_lead;
  pager_param_pkg::rate_e rate;

  assign dc_opt     = param_ff[`BIT_DC_OPT];
  assign aux_slow   = param_ff[`BIT_AUX_FREQ];
  assign aux_off    = param_ff[`BIT_AUX_OFF];
  assign polarity   = param_ff[`BIT_POLARITY];
  assign filt_en    = param_ff[`BIT_FILT_EN];
  assign filt_sel   = param_ff[`FILT_MSB:`FILT_LSB];
  assign pll_lead   = param_ff[`PLL_MSB:`PLL_LSB];
  assign radio_lead = param_ff[`RADIO_MSB:`RADIO_LSB];
  assign rate = pager_param_pkg::rate_e'(param_ff[`RATE_MSB:`RATE_LSB]);

  // Noise filter and polarity on the received data.
  logic        filt_ff, nxt_filt;
  logic [31:0] fcnt_ff, nxt_fcnt;
  logic        sig_pol;
  logic [31:0] filt_len;

  always_comb
  begin
    sig_pol  = sig_b_ff ^ polarity;
    filt_len = 32'(FILT_BASE_CYC) * (32'(filt_sel) + 32'h1);
    nxt_filt = filt_ff;
    nxt_fcnt = 32'h0;
    if (!filt_en)
      nxt_filt = sig_pol;
    else if (sig_pol != filt_ff)
    begin
      nxt_fcnt = fcnt_ff + 32'h1;
      if (nxt_fcnt >= filt_len)
      begin
        nxt_filt = sig_pol;
        nxt_fcnt = 32'h0;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst)
    begin
      filt_ff <= 1'b0;
      fcnt_ff <= 32'h0;
    end
    else
    begin
      filt_ff <= nxt_filt;
      fcnt_ff <= nxt_fcnt;
    end
  end

  // Idle-mode intermittent timing and the three strobes.
  pager_param_pkg::strobe_st_e st_ff, nxt_st;
  pager_param_pkg::mode_e      mode;
  logic [31:0] tick_ff, nxt_tick, step_cyc, slot_cyc;
  logic [5:0]  lead_ff, nxt_lead;
  logic        rp_ff, nxt_rp, dc_ff, nxt_dc, pl_ff, nxt_pl;

  assign mode = pager_param_pkg::mode_e'(mode_in);

  always_comb
  begin
    unique case (rate)
      pager_param_pkg::RATE_1200:
      begin
        step_cyc = 32'(STEP_1200_CYC);
        slot_cyc = 32'(SLOT_1200_CYC);
      end
      pager_param_pkg::RATE_2400:
      begin
        step_cyc = 32'(STEP_2400_CYC);
        slot_cyc = 32'(SLOT_2400_CYC);
      end
      default:
      begin
        step_cyc = 32'(STEP_512_CYC);
        slot_cyc = 32'(SLOT_512_CYC);
      end
    endcase
    nxt_st   = st_ff;
    nxt_tick = tick_ff;
    nxt_lead = lead_ff;
    if (mode != pager_param_pkg::MODE_IDLE)
      nxt_st = pager_param_pkg::ST_WAIT;
    else
      unique case (st_ff)
        pager_param_pkg::ST_WAIT:
          if (idle_cycle_in)
          begin
            nxt_st   = pager_param_pkg::ST_LEAD;
            nxt_lead = `LEAD_START;
            nxt_tick = step_cyc - 32'h1;
          end
        pager_param_pkg::ST_LEAD:
          if (tick_ff != 32'h0)
            nxt_tick = tick_ff - 32'h1;
          else if (lead_ff == 6'h01)
          begin
            nxt_st   = pager_param_pkg::ST_SLOT;
            nxt_tick = slot_cyc - 32'h1;
          end
          else
          begin
            nxt_lead = lead_ff - 6'h01;
            nxt_tick = step_cyc - 32'h1;
          end
        pager_param_pkg::ST_SLOT:
          if (tick_ff != 32'h0)
            nxt_tick = tick_ff - 32'h1;
          else
            nxt_st = pager_param_pkg::ST_WAIT;
      endcase
    // Strobes take the state being entered so they land on the step edge.
    nxt_rp = 1'b0;
    nxt_pl = 1'b0;
    nxt_dc = 1'b0;
    unique case (mode)
      pager_param_pkg::MODE_PREAMBLE, pager_param_pkg::MODE_LOCK:
      begin
        nxt_rp = 1'b1;
        nxt_pl = 1'b1;
        nxt_dc = (mode == pager_param_pkg::MODE_LOCK) && dc_opt &&
                 sync_window_in;
      end
      pager_param_pkg::MODE_IDLE:
      begin
        if (nxt_st == pager_param_pkg::ST_LEAD)
        begin
          nxt_rp = nxt_lead <= radio_lead;
          nxt_pl = nxt_lead <= pll_lead;
          nxt_dc = !dc_opt && (nxt_lead <= radio_lead);
        end
        else if (nxt_st == pager_param_pkg::ST_SLOT)
        begin
          nxt_rp = 1'b1;
          nxt_pl = 1'b1;
          nxt_dc = dc_opt;
        end
      end
      pager_param_pkg::MODE_OFF:
        nxt_rp = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst)
    begin
      st_ff   <= pager_param_pkg::ST_WAIT;
      tick_ff <= 32'h0;
      lead_ff <= 6'h00;
      rp_ff   <= 1'b0;
      dc_ff   <= 1'b0;
      pl_ff   <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      tick_ff <= nxt_tick;
      lead_ff <= nxt_lead;
      rp_ff   <= nxt_rp;
      dc_ff   <= nxt_dc;
      pl_ff   <= nxt_pl;
    end
  end

  // In-range hold timer with miss and mode-path cancellation.
  logic [31:0] ir_ff, nxt_ir;
  logic [1:0]  miss_ff, nxt_miss;
  logic [1:0]  pmode_ff;
  logic        via_lock_ff, nxt_via_lock;

  always_comb
  begin
    nxt_ir       = (ir_ff != 32'h0) ? ir_ff - 32'h1 : 32'h0;
    nxt_miss     = miss_ff;
    nxt_via_lock = via_lock_ff;
    if (mode_in != pmode_ff)
      nxt_via_lock = (pmode_ff == 2'(pager_param_pkg::MODE_LOCK)) &&
                     (mode == pager_param_pkg::MODE_IDLE);
    if (sync_missed_in)
    begin
      nxt_miss = (miss_ff == 2'h2) ? 2'h2 : miss_ff + 2'h1;
      if (miss_ff != 2'h0)
        nxt_ir = 32'h0;
    end
    if (via_lock_ff && (mode == pager_param_pkg::MODE_PREAMBLE) &&
        (rate != pager_param_pkg::RATE_512))
      nxt_ir = 32'h0;
    if (sync_found_in && (sync_errors_in <= 3'h2) &&
        (mode != pager_param_pkg::MODE_OFF))
    begin
      nxt_ir   = 32'(IN_RANGE_CYC);
      nxt_miss = 2'h0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst)
    begin
      ir_ff       <= 32'h0;
      miss_ff     <= 2'h0;
      pmode_ff    <= 2'h0;
      via_lock_ff <= 1'b0;
    end
    else
    begin
      ir_ff       <= nxt_ir;
      miss_ff     <= nxt_miss;
      pmode_ff    <= mode_in;
      via_lock_ff <= nxt_via_lock;
    end
  end

  // Aux clock divider, message end and miscellaneous outputs.
  logic [9:0] aux_cnt_ff, nxt_aux_cnt;
  logic       aux_ff, nxt_aux, att_ff, mend_ff, nxt_mend, ir_out_ff;
  logic [9:0] aux_half;

  always_comb
  begin
    aux_half = aux_slow ? 10'(2 * AUX_HALF_CYC - 1) :
                          10'(AUX_HALF_CYC - 1);
    nxt_aux_cnt = aux_cnt_ff + 10'h001;
    nxt_aux     = aux_ff;
    if (aux_off)
    begin
      nxt_aux_cnt = 10'h000;
      nxt_aux     = 1'b0;
    end
    else if (aux_cnt_ff >= aux_half)
    begin
      nxt_aux_cnt = 10'h000;
      nxt_aux     = ~aux_ff;
    end
    nxt_mend = break_cmd_in ||
               (!param_ff[`BIT_MSG_END] && in_message_in &&
                (idle_code_in || other_address_in));
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst)
    begin
      aux_cnt_ff <= 10'h000;
      aux_ff     <= 1'b0;
      att_ff     <= 1'b1;
      mend_ff    <= 1'b0;
      ir_out_ff  <= 1'b0;
    end
    else
    begin
      aux_cnt_ff <= nxt_aux_cnt;
      aux_ff     <= nxt_aux;
      att_ff     <= !data_ready_in;
      mend_ff    <= nxt_mend;
      ir_out_ff  <= nxt_ir != 32'h0;
    end
  end

  assign attention_line_out     = att_ff;
  assign filtered_data_out      = filt_ff;
  assign in_range_indicator_out = ir_out_ff;
  assign radio_power_strobe_out = rp_ff;
  assign dc_adjust_strobe_out   = dc_ff;
  assign pll_setup_strobe_out   = pl_ff;
  assign aux_clock_out          = aux_ff;
  assign message_end_out        = mend_ff;
  assign address_as_data_out    = param_ff[`BIT_MSG_END];
  assign rate_out               = param_ff[`RATE_MSB:`RATE_LSB];
  assign rate_error_limit_out   = lim_ff;
endmodule
`default_nettype wire

// [sim/pager_param_ctrl_monitor.sv]
// Concurrent checks on the parameter control block's ports.
`timescale 1ns/1ps
`default_nettype none
module pager_param_ctrl_monitor (
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  input wire logic [1:0] mode_in,
  input wire logic       sync_window_in,
  input wire logic       sync_found_in,
  input wire logic [2:0] sync_errors_in,
  input wire logic       sync_missed_in,
  input wire logic       break_cmd_in,
  input wire logic       in_range_indicator_out,
  input wire logic       dc_adjust_strobe_out,
  input wire logic       message_end_out,
  input wire logic       address_as_data_out,
  input wire logic [1:0] rate_out
);
  default clocking mon_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_range_rise: assert property (
    sync_found_in && sync_errors_in <= 3'h2 && mode_in != 2'h3
    |=> in_range_indicator_out) else $error("in-range not raised");
  chk_range_cause: assert property (
    $rose(in_range_indicator_out) |-> $past(sync_found_in)
    && $past(sync_errors_in) <= 3'h2) else $error("in-range rose unprompted");
  chk_range_hold: assert property (
    $rose(in_range_indicator_out) |-> (in_range_indicator_out[*8]
    or ##[0:7] (sync_missed_in || mode_in == 2'h0)))
    else $error("in-range dropped early");
  chk_dc_preamble: assert property (
    $past(mode_in) == 2'h0 && $past(mode_in, 2) == 2'h0
    |-> !dc_adjust_strobe_out) else $error("adjust strobe high in preamble");
  chk_dc_lock: assert property (
    dc_adjust_strobe_out && $past(mode_in) == 2'h1
    && $past(mode_in, 2) == 2'h1 |-> $past(sync_window_in))
    else $error("adjust strobe outside sync window");
  chk_break_end: assert property (
    break_cmd_in |=> message_end_out) else $error("break did not end message");
  chk_addr_kept: assert property (
    address_as_data_out && $stable(address_as_data_out) && !break_cmd_in
    |=> !message_end_out) else $error("message ended without break");
  chk_rate_legal: assert property (
    rate_out != 2'h3) else $error("rate code 11 applied");
endmodule

bind pager_param_ctrl pager_param_ctrl_monitor mon_u (
  .sys_clk_in, .reset_n_in, .mode_in, .sync_window_in, .sync_found_in,
  .sync_errors_in, .sync_missed_in, .break_cmd_in, .in_range_indicator_out,
  .dc_adjust_strobe_out, .message_end_out, .address_as_data_out, .rate_out);
`default_nettype wire

// [sim/host_link_model.sv]
// Host controller side of the serial parameter link.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  input  wire logic attention_line_in,
  output logic      link_clk_out,
  output logic      link_data_out
);
  initial
  begin
    link_clk_out = 1'b0;
    link_data_out = 1'b0;
  end

  // Data changes while the clock is low so the rising edge sees it settled.
  task automatic pulse(input logic d);
    link_data_out = d;
    #7.5 link_clk_out = 1'b1;
    #7.5 link_clk_out = 1'b0;
  endtask

  // The clock stands still after a word; the data line shows the inverted last bit.
  task automatic send(input logic [31:0] w);
    wait (attention_line_in === 1'b1);
    for (int i = 31; i >= 0; i--)
      pulse(w[i]);
    link_data_out = ~w[0];
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the parameter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       sys_clk_in, reset_n_in, init_reset_n_in, link_clk_in;
  logic       link_data_in, data_ready_in, signal_in, idle_cycle_in;
  logic       sync_window_in, sync_found_in, sync_missed_in, in_message_in;
  logic       idle_code_in, other_address_in, break_cmd_in;
  logic [1:0] mode_in, rate_out;
  logic [2:0] sync_errors_in;
  logic [3:0] rate_error_limit_out;
  logic       attention_line_out, filtered_data_out, in_range_indicator_out;
  logic       radio_power_strobe_out, dc_adjust_strobe_out, aux_clock_out;
  logic       pll_setup_strobe_out, message_end_out, address_as_data_out;
  int         num_errors, checked, cycles;

  pager_param_ctrl #(
    .STEP_1200_CYC(4), .SLOT_1200_CYC(8), .IN_RANGE_CYC(50),
    .FILT_BASE_CYC(2)
  ) dut_u (
    .sys_clk_in, .reset_n_in, .init_reset_n_in, .link_clk_in, .link_data_in,
    .data_ready_in, .signal_in, .mode_in, .idle_cycle_in, .sync_window_in,
    .sync_found_in, .sync_errors_in, .sync_missed_in, .in_message_in,
    .idle_code_in, .other_address_in, .break_cmd_in, .attention_line_out,
    .filtered_data_out, .in_range_indicator_out, .radio_power_strobe_out,
    .dc_adjust_strobe_out, .pll_setup_strobe_out, .aux_clock_out,
    .message_end_out, .address_as_data_out, .rate_out, .rate_error_limit_out);

  host_link_model host_u (
    .attention_line_in(attention_line_out),
    .link_clk_out     (link_clk_in),
    .link_data_out    (link_data_in));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      num_errors++;
      $display("Error timeout expected done seen hang");
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  function automatic logic [31:0] pw(input logic [3:0] fl,
    input logic [1:0] rt, input logic pol, input logic [5:0] m, n,
    input logic [2:0] fi, er);
    return {7'h20, fl, rt, pol, m, n, fi, er};
  endfunction

  task automatic wr(input logic [31:0] w);
    host_u.send(w);
    cyc(8);
  endtask

  task automatic t_fields;
    logic [31:0] bad [6];
    bad = '{pw(4'h0, 2'h3, 1'b0, 6'h03, 6'h02, 3'h0, 3'h0),
            pw(4'h0, 2'h0, 1'b0, 6'h3f, 6'h02, 3'h0, 3'h0),
            pw(4'h0, 2'h0, 1'b0, 6'h03, 6'h3e, 3'h0, 3'h0),
            pw(4'h0, 2'h0, 1'b0, 6'h03, 6'h01, 3'h0, 3'h0),
            pw(4'h0, 2'h0, 1'b0, 6'h04, 6'h05, 3'h0, 3'h0),
            pw(4'h0, 2'h0, 1'b0, 6'h03, 6'h02, 3'h0, 3'h0) ^ 32'h80000000};
    check("reset rate", rate_out, 2'h0);
    check("reset limit", rate_error_limit_out, 4'h1);
    data_ready_in = 1'b1;
    cyc(2);
    check("attention busy", attention_line_out, 1'b0);
    data_ready_in = 1'b0;
    cyc(2);
    check("attention free", attention_line_out, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      wr(pw(4'h4, 2'(i % 3), 1'b0, 6'h03, 6'h02, 3'h0, 3'(i)));
      check("rate", rate_out, i % 3);
      check("limit", rate_error_limit_out, i + 1);
      check("address as data", address_as_data_out, 1'b1);
    end
    foreach (bad[k])
    begin
      wr(bad[k]);
      check("refused word", rate_out, 2'h1);
    end
    $display("field test done");
  endtask

  task automatic t_strobes(input logic opt, input logic [5:0] n);
    int r, p, d;
    r = 0;
    p = 0;
    d = 0;
    wr(pw({opt, 3'h0}, 2'h1, 1'b0, n + 6'h01, n, 3'h0, 3'h0));
    mode_in = 2'h2;
    cyc(2);
    idle_cycle_in = 1'b1;
    cyc(1);
    idle_cycle_in = 1'b0;
    repeat (300)
    begin
      cyc(1);
      r += int'(radio_power_strobe_out === 1'b1);
      p += int'(pll_setup_strobe_out === 1'b1);
      d += int'(dc_adjust_strobe_out === 1'b1);
    end
    check("radio strobe", r, n * 4 + 8);
    check("pll strobe", p, n * 4 + 12);
    check("adjust strobe", d, opt ? 8 : n * 4);
    $display("strobe test done");
  endtask

  task automatic found(input logic [2:0] e);
    sync_errors_in = e;
    sync_found_in = 1'b1;
    cyc(1);
    sync_found_in = 1'b0;
    cyc(2);
  endtask

  task automatic miss;
    sync_missed_in = 1'b1;
    cyc(1);
    sync_missed_in = 1'b0;
    cyc(2);
  endtask

  task automatic t_range;
    int h;
    h = 0;
    mode_in = 2'h1;
    sync_window_in = 1'b1;
    cyc(3);
    sync_window_in = 1'b0;
    found(3'h3);
    check("range on 3 errors", in_range_indicator_out, 1'b0);
    found(3'h2);
    repeat (60)
    begin
      cyc(1);
      h += int'(in_range_indicator_out === 1'b1);
    end
    // The window opens three cycles after the hold timer is loaded.
    check("range held", h, 47);
    found(3'h2);
    miss();
    check("range one miss", in_range_indicator_out, 1'b1);
    miss();
    check("range two misses", in_range_indicator_out, 1'b0);
    mode_in = 2'h2;
    found(3'h0);
    check("range idle after lock", in_range_indicator_out, 1'b1);
    mode_in = 2'h0;
    cyc(3);
    check("range back to preamble", in_range_indicator_out, 1'b0);
    $display("in-range test done");
  endtask

  task automatic t_msg(input logic sel);
    wr(pw({1'b0, sel, 2'h0}, 2'h0, 1'b0, 6'h03, 6'h02, 3'h0, 3'h0));
    in_message_in = 1'b1;
    other_address_in = 1'b1;
    cyc(2);
    check("end on address", message_end_out, !sel);
    other_address_in = 1'b0;
    idle_code_in = 1'b1;
    cyc(2);
    check("end on idle code", message_end_out, !sel);
    idle_code_in = 1'b0;
    break_cmd_in = 1'b1;
    cyc(2);
    check("end on break", message_end_out, 1'b1);
    break_cmd_in = 1'b0;
    in_message_in = 1'b0;
    $display("message test done");
  endtask

  task automatic t_filter;
    wr(pw(4'h0, 2'h0, 1'b1, 6'h03, 6'h02, 3'h0, 3'h0));
    signal_in = 1'b1;
    cyc(6);
    check("inverted input", filtered_data_out, 1'b0);
    wr(pw(4'h0, 2'h0, 1'b0, 6'h03, 6'h02, 3'h7, 3'h0));
    cyc(12);
    signal_in = 1'b0;
    cyc(5);
    check("strong filter holds", filtered_data_out, 1'b1);
    cyc(10);
    check("filter passes", filtered_data_out, 1'b0);
    $display("filter test done");
  endtask

  task automatic half(input int exp);
    int c;
    c = 0;
    while (aux_clock_out !== 1'b0)
      cyc(1);
    while (aux_clock_out !== 1'b1)
      cyc(1);
    while (aux_clock_out === 1'b1)
    begin
      cyc(1);
      c++;
    end
    check("aux half period", c, exp);
  endtask

  task automatic t_aux;
    int c;
    c = 0;
    half(325);
    wr(pw(4'h2, 2'h2, 1'b0, 6'h03, 6'h02, 3'h0, 3'h5));
    half(650);
    wr(pw(4'h1, 2'h2, 1'b0, 6'h03, 6'h02, 3'h0, 3'h5));
    repeat (700)
    begin
      cyc(1);
      c += int'(aux_clock_out === 1'b1);
    end
    check("aux stopped", c, 0);
    $display("aux clock test done");
  endtask

  initial
  begin
    {reset_n_in, data_ready_in, signal_in, idle_cycle_in, sync_window_in,
     sync_found_in, sync_missed_in, in_message_in, idle_code_in,
     other_address_in, break_cmd_in, mode_in, sync_errors_in} = '0;
    init_reset_n_in = 1'b1;
    repeat (7) host_u.pulse(1'b0);
    @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    // Two link edges pass the reset synchroniser; the third is bit one.
    repeat (2) host_u.pulse(1'b1);
    t_fields();
    t_strobes(1'b0, 6'h02);
    t_strobes(1'b1, 6'h05);
    t_range();
    t_msg(1'b0);
    t_msg(1'b1);
    t_filter();
    t_aux();
    init_reset_n_in = 1'b0;
    cyc(5);
    init_reset_n_in = 1'b1;
    cyc(5);
    check("rate after init", rate_out, 2'h0);
    check("limit after init", rate_error_limit_out, 4'h1);
    stop_test();
  end
endmodule
`default_nettype wire
